// >>> common/ep_status_pkg.sv
// ep_status_pkg: constants shared by the endpoint status/control logic.
// assumes one 100 MHz system clock and the controller's register port.
//
// Overview of operation
// RULE_01 - direction bit only for control endpoints
// RULE_02 - firmware sets direction first after setup
// RULE_03 - firmware clears direction for control-out status
// RULE_04 - bank1 flag set on ping-pong store, naks
// RULE_05 - stall request answers next handshake with stall
// RULE_06 - firmware sets ready after loading fifo
// RULE_07 - ready with empty fifo sends zero length
// RULE_08 - ready clears on send iso, ack otherwise
// RULE_09 - stall-sent flag set, cleared by setup
// RULE_10 - iso crc flag follows last packet crc
// RULE_11 - setup sets flag, clears all other bits
// RULE_12 - firmware clears setup flag after reading
// RULE_13 - bank0 flag set on store, naks further
// RULE_14 - control setup may overwrite full bank0
// RULE_15 - firmware clears bank0 flag after reading
// RULE_16 - in-complete set on send or ack
// RULE_17 - firmware clears in-complete before ready again
// RULE_18 - register access steered by endpoint select
// RULE_19 - endpoint select field is bits one..zero
// RULE_20 - kind field: control, iso, bulk encodings
// RULE_21 - per-endpoint enable gates interrupt
// RULE_22 - interrupt is or of flags gated
package ep_status_pkg;
  localparam int NUM_EP = 3;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'hce;
  localparam logic [7:0] ADDR_ENDPOINT_SELECT = 8'hc7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SELECT_MASK = 8'h03;
  localparam int BIT_DIR = 7;
  localparam int BIT_OUT_B1 = 6;
  localparam int BIT_STALL_RQ = 5;
  localparam int BIT_IN_READY = 4;
  localparam int BIT_STALL_CRC = 3;
  localparam int BIT_SETUP = 2;
  localparam int BIT_OUT_B0 = 1;
  localparam int BIT_IN_DONE = 0;
  localparam logic [7:0] FLAG_IRQ_MASK = 8'h4f;
  localparam logic [1:0] KIND_CONTROL = 2'h0;
  localparam logic [1:0] KIND_ISO = 2'h1;
  localparam logic [1:0] KIND_BULK = 2'h2;
  // handshake codes toward the serial engine
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} handshake_e;
endpackage

// >>> verif/usb_endpoint_status_control_tb.sv
// usb_endpoint_status_control_tb: self-checking bench.
// assumes usb_host_model plays the host; bench plays firmware.
`timescale 1ns/100ps
module usb_endpoint_status_control_tb;
  import ep_status_pkg::*;
  localparam logic [7:0] SC = ADDR_STATUS_CONTROL;
  localparam logic [7:0] SEL = ADDR_ENDPOINT_SELECT;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [2:0] en = 3'h0;
  logic empty = 1'b0;
  logic [7:0] rdata;
  logic [7:0] ev;
  logic [1:0] tep;
  logic bank;
  handshake_e ohs;
  handshake_e ihs;
  logic zlp;
  logic acc;
  logic [2:0] irq;
  logic [1:0] esel;
  logic [7:0] expq[$];
  int n_errors = 0;
  int check_count = 0;
  initial
  begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  usb_host_model host (.i_sys_clk(i_sys_clk), .o_txn_ep(tep), .o_bank(bank), .o_ev(ev));
  usb_endpoint_status_control DUT (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_endpoint_kind_field(6'h18), .i_pingpong(3'h2),
    .i_endpoint_interrupt_enables(en), .i_txn_ep(tep), .i_setup_ok(ev[1]),
    .i_out_stored(ev[2]), .i_out_bank(bank), .i_in_sent(ev[3]),
    .i_in_acked(ev[4]), .i_stall_sent(ev[5]), .i_crc_bad(ev[6]),
    .i_crc_good(ev[7]), .i_fifo_empty(empty), .o_out_handshake(ohs),
    .o_in_handshake(ihs), .o_send_zlp(zlp), .o_setup_accept(acc),
    .o_ep_irq(irq), .o_endpoint_select_field(esel));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask
  // note the expected byte, then strobe the read
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    expq.push_back(exp);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_sys_clk);
    rd <= 1'b0;
  endtask
  // read data lands the cycle after the strobe is taken
  always @(posedge i_sys_clk)
  begin
    if (rd_q)
      check("rdata", rdata, expq.pop_front());
    rd_q <= rd;
  end
  // watchdog
  initial
  begin
    #20000;
    n_errors++;
    print_verdict();
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    void'($urandom(67559));
    repeat (4) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd_reg(SC, STATUS_RESET);
    rd_reg(8'h00, 8'h00);
    // ep0 control: setup wipes other bits
    wr_reg(SC, 8'hb0);
    en <= 3'h1;
    host.evt(1, 2'h0, 1'b0);
    rd_reg(SC, 8'h04);
    @(negedge i_sys_clk);
    check("irq0", {5'h0, irq}, 8'h01);
    @(posedge i_sys_clk);
    en <= 3'h0;
    @(negedge i_sys_clk);
    check("irq0off", {5'h0, irq}, 8'h00);
    wr_reg(SC, 8'h80);
    rd_reg(SC, 8'h80);
    wr_reg(SC, 8'h00);
    host.evt(2, 2'h0, 1'b0);
    @(negedge i_sys_clk);
    check("ohs0", 8'(ohs), 8'(HS_NAK));
    check("acc0", {7'h0, acc}, 8'h01);
    host.evt(1, 2'h0, 1'b0);
    rd_reg(SC, 8'h04);
    // ep1 bulk, ping-pong; select upper bits random
    wr_reg(SEL, (8'($urandom()) & 8'hfc) | 8'h01);
    @(negedge i_sys_clk);
    check("esel", {6'h0, esel}, 8'h01);
    wr_reg(SC, 8'h80);
    rd_reg(SC, 8'h00);
    host.evt(2, 2'h1, 1'b0);
    host.evt(2, 2'h1, 1'b1);
    rd_reg(SC, 8'h42);
    en <= 3'h2;
    @(negedge i_sys_clk);
    check("irq1", {5'h0, irq}, 8'h02);
    check("ohs1", 8'(ohs), 8'(HS_NAK));
    wr_reg(SC, 8'h20);
    @(negedge i_sys_clk);
    check("ihs1", 8'(ihs), 8'(HS_STALL));
    check("ohs1b", 8'(ohs), 8'(HS_STALL));
    host.evt(5, 2'h1, 1'b0);
    rd_reg(SC, 8'h28);
    wr_reg(SC, 8'h00);
    empty <= 1'b1;
    wr_reg(SC, 8'h10);
    @(negedge i_sys_clk);
    check("zlp", {7'h0, zlp}, 8'h01);
    check("ihs1b", 8'(ihs), 8'(HS_ACK));
    host.evt(3, 2'h1, 1'b0);
    rd_reg(SC, 8'h10);
    host.evt(4, 2'h1, 1'b0);
    rd_reg(SC, 8'h01);
    @(negedge i_sys_clk);
    check("ihs1c", 8'(ihs), 8'(HS_NAK));
    check("zlp0", {7'h0, zlp}, 8'h00);
    // ep2 isochronous
    wr_reg(SEL, 8'h02);
    wr_reg(SC, 8'h10);
    host.evt(3, 2'h2, 1'b0);
    rd_reg(SC, 8'h01);
    wr_reg(SC, 8'h00);
    host.evt(6, 2'h2, 1'b0);
    rd_reg(SC, 8'h08);
    host.evt(7, 2'h2, 1'b0);
    rd_reg(SC, 8'h00);
    host.evt(2, 2'h2, 1'b0);
    @(negedge i_sys_clk);
    check("ohs2", 8'(ohs), 8'(HS_ACK));
    wr_reg(SEL, 8'h03);
    rd_reg(SC, 8'h00);
    wr_reg(SEL, 8'h02);
    rd_reg(SC, 8'h02);
    repeat (3) @(posedge i_sys_clk);
    print_verdict();
  end
endmodule

// >>> verif/usb_host_model.sv
// usb_host_model: issues link events toward the endpoint logic.
// assumes the bench calls evt from its main process.
`timescale 1ns/100ps
module usb_host_model
(
  // clock
  input wire logic i_sys_clk,
  // transaction endpoint, bank and event pulses
  output logic [1:0] o_txn_ep,
  output logic o_bank,
  output logic [7:0] o_ev
);
  initial
  begin
    o_txn_ep = 2'h0;
    o_bank = 1'b0;
    o_ev = 8'h00;
  end
  // one-cycle pulse of event bit code; code 0 only aims at ep
  task automatic evt(input int code, input logic [1:0] ep, input logic bk);
    @(posedge i_sys_clk);
    o_txn_ep <= ep;
    o_bank <= bk;
    o_ev <= 8'h01 << code;
    @(posedge i_sys_clk);
    o_ev <= 8'h00;
    o_bank <= ~bk; // bank qualifier is inverted outside the pulse
  endtask
endmodule

// >>> verilog/ep_slot.sv
// ep_slot: status/control byte of one endpoint.
// assumes flag events are one-cycle pulses from the serial engine.
`timescale 1ns/100ps
module ep_slot
  import ep_status_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // firmware write to this slot
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // configuration
  input wire logic [1:0] i_kind,
  input wire logic i_pingpong,
  // link events
  input wire logic i_setup_ok,
  input wire logic i_out_b0_stored,
  input wire logic i_out_b1_stored,
  input wire logic i_in_sent,
  input wire logic i_in_acked,
  input wire logic i_stall_sent,
  input wire logic i_crc_bad,
  input wire logic i_crc_good,
  // state
  output logic [7:0] o_status
);
  typedef struct packed {logic [7:0] stat;} slot_s;
  slot_s cur, next_cur;
  logic iso;

  assign iso = (i_kind == KIND_ISO);
  assign o_status = cur.stat;

  // firmware write, then hardware events; hardware events win over the write, and setup overrides all
  always_comb
  begin
    next_cur = cur;
    if (i_wr)
    begin
      next_cur.stat = i_wdata;
      if (i_kind != KIND_CONTROL)
        next_cur.stat[BIT_DIR] = 1'b0; // RULE_01
    end
    if (i_out_b1_stored && i_pingpong)
      next_cur.stat[BIT_OUT_B1] = 1'b1; // RULE_04
    if (i_out_b0_stored)
      next_cur.stat[BIT_OUT_B0] = 1'b1; // RULE_13
    if (i_in_sent && iso)
    begin
      next_cur.stat[BIT_IN_READY] = 1'b0; // RULE_08
      next_cur.stat[BIT_IN_DONE] = 1'b1; // RULE_16
    end
    if (i_in_acked && !iso)
    begin
      next_cur.stat[BIT_IN_READY] = 1'b0; // RULE_08
      next_cur.stat[BIT_IN_DONE] = 1'b1; // RULE_16
    end
    if (i_stall_sent && !iso)
      next_cur.stat[BIT_STALL_CRC] = 1'b1; // RULE_09
    if (iso && i_crc_bad)
      next_cur.stat[BIT_STALL_CRC] = 1'b1; // RULE_10
    else if (iso && i_crc_good)
      next_cur.stat[BIT_STALL_CRC] = 1'b0; // RULE_10
    // setup clears all else, stall-sent flag included
    if (i_setup_ok)
      next_cur.stat = 8'h04; // RULE_11 RULE_09
  end

  // state register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      cur.stat <= STATUS_RESET;
    else
      cur <= next_cur;
  end

  a_setup_clears: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_setup_ok |=> o_status == 8'h04) else $error("setup did not clear register"); // RULE_11
  a_ack_done: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_in_acked && !iso && !i_setup_ok) |=> (o_status[BIT_IN_DONE] && !o_status[BIT_IN_READY]))
    else $error("ack did not complete in packet"); // RULE_16
  a_iso_sent: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_in_sent && iso && !i_setup_ok) |=> !o_status[BIT_IN_READY])
    else $error("iso send did not clear ready"); // RULE_08
  a_b0_set: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_out_b0_stored && !i_setup_ok) |=> o_status[BIT_OUT_B0])
    else $error("bank0 flag not set"); // RULE_13
  a_b1_set: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_out_b1_stored && i_pingpong && !i_setup_ok) |=> o_status[BIT_OUT_B1])
    else $error("bank1 flag not set"); // RULE_04
  a_crc_flag: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (iso && i_crc_bad && !i_setup_ok) |=> o_status[BIT_STALL_CRC])
    else $error("crc flag not set"); // RULE_10
endmodule

// >>> verilog/usb_endpoint_status_control.sv
// usb_endpoint_status_control: indexed status/control register of all endpoints.
// assumes firmware register port strobes and serial engine event pulses on i_sys_clk.
`timescale 1ns/100ps
module usb_endpoint_status_control
  import ep_status_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // firmware register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // endpoint configuration
  input wire logic [5:0] i_endpoint_kind_field,
  input wire logic [2:0] i_pingpong,
  input wire logic [2:0] i_endpoint_interrupt_enables,
  // serial engine: endpoint of current transaction and its events
  input wire logic [1:0] i_txn_ep,
  input wire logic i_setup_ok,
  input wire logic i_out_stored,
  input wire logic i_out_bank,
  input wire logic i_in_sent,
  input wire logic i_in_acked,
  input wire logic i_stall_sent,
  input wire logic i_crc_bad,
  input wire logic i_crc_good,
  input wire logic i_fifo_empty,
  // answers to the serial engine
  output handshake_e o_out_handshake,
  output handshake_e o_in_handshake,
  output logic o_send_zlp,
  output logic o_setup_accept,
  // interrupts and state
  output logic [2:0] o_ep_irq,
  output logic [1:0] o_endpoint_select_field
);
  typedef struct packed {logic [1:0] sel; logic [7:0] rdata;} top_s;
  top_s cur, next_cur;
  logic [7:0] status [NUM_EP];
  logic [NUM_EP-1:0] slot_wr;
  logic [7:0] sel_stat, txn_stat;
  logic [1:0] txn_kind;
  logic txn_pp;

  // kind of an endpoint from the packed kind field; no endpoint 3, so it is never control
  function automatic logic [1:0] kind_of(input logic [5:0] f, input logic [1:0] ep);
    if (ep < 2'(NUM_EP))
      kind_of = f[{ep, 1'b0} +: 2]; // RULE_20
    else
      kind_of = KIND_BULK;
  endfunction

  // ******************************
  // endpoint slots
  // ******************************
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : slot
      logic hit;
      logic to_b1;
      assign hit = (i_txn_ep == 2'(g));
      // only a ping-pong endpoint owns bank 1; others always store to bank 0
      assign to_b1 = i_out_bank && i_pingpong[g]; // RULE_04
      assign slot_wr[g] = i_reg_wr && (i_reg_addr == ADDR_STATUS_CONTROL)
                          && (cur.sel == 2'(g)); // RULE_18
      ep_slot u_slot (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr(slot_wr[g]),
        .i_wdata(i_reg_wdata),
        .i_kind(kind_of(i_endpoint_kind_field, g[1:0])),
        .i_pingpong(i_pingpong[g]),
        .i_setup_ok(hit && i_setup_ok),
        .i_out_b0_stored(hit && i_out_stored && !to_b1),
        .i_out_b1_stored(hit && i_out_stored && to_b1),
        .i_in_sent(hit && i_in_sent),
        .i_in_acked(hit && i_in_acked),
        .i_stall_sent(hit && i_stall_sent),
        .i_crc_bad(hit && i_crc_bad),
        .i_crc_good(hit && i_crc_good),
        .o_status(status[g])
      );
      // flags or'ed and gated by enable
      assign o_ep_irq[g] = i_endpoint_interrupt_enables[g]
                           && |(status[g] & FLAG_IRQ_MASK); // RULE_21 RULE_22
    end
  endgenerate

  // ******************************
  // handshake decisions
  // ******************************
  always_comb
  begin
    txn_stat = (i_txn_ep < 2'd3) ? status[i_txn_ep] : 8'h00;
    sel_stat = (cur.sel < 2'd3) ? status[cur.sel] : 8'h00;
    txn_kind = kind_of(i_endpoint_kind_field, i_txn_ep);
    txn_pp = (i_txn_ep < 2'd3) ? i_pingpong[i_txn_ep] : 1'b0;
    o_out_handshake = HS_ACK;
    if (txn_stat[BIT_STALL_RQ])
      o_out_handshake = HS_STALL; // RULE_05
    else if (txn_kind != KIND_ISO)
    begin
      // bank qualifier counts only on ping-pong endpoints
      if ((i_out_bank && txn_pp) ? txn_stat[BIT_OUT_B1] : txn_stat[BIT_OUT_B0])
        o_out_handshake = HS_NAK; // RULE_04 RULE_13
    end
    o_in_handshake = HS_NAK;
    if (txn_stat[BIT_STALL_RQ])
      o_in_handshake = HS_STALL; // RULE_05
    else if (txn_stat[BIT_IN_READY])
      o_in_handshake = HS_ACK;
    o_send_zlp = txn_stat[BIT_IN_READY] && i_fifo_empty; // RULE_07
    o_setup_accept = (txn_kind == KIND_CONTROL); // RULE_14
  end

  // ******************************
  // register port
  // ******************************
  always_comb
  begin
    next_cur = cur;
    if (i_reg_wr && i_reg_addr == ADDR_ENDPOINT_SELECT)
      next_cur.sel = i_reg_wdata[1:0]; // RULE_19
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        ADDR_STATUS_CONTROL: next_cur.rdata = sel_stat; // RULE_18
        ADDR_ENDPOINT_SELECT: next_cur.rdata = {6'h00, cur.sel};
        default: next_cur.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign o_reg_rdata = cur.rdata;
  assign o_endpoint_select_field = cur.sel;

  a_stall_answer: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    txn_stat[BIT_STALL_RQ] |-> (o_in_handshake == HS_STALL && o_out_handshake == HS_STALL))
    else $error("stall not answered"); // RULE_05
  a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !i_endpoint_interrupt_enables[0] |-> !o_ep_irq[0])
    else $error("irq without enable"); // RULE_21
  a_read_steer: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == ADDR_STATUS_CONTROL) |=> o_reg_rdata == $past(sel_stat))
    else $error("read not steered"); // RULE_18
endmodule
